// *** logic/rcadc_pkg.sv ***
// Constants and types shared by the RC-oscillation converter control block
package rcadc_pkg;

  // ***************************************************
  // Register map (byte addresses, halfword aligned)
  // ***************************************************
  localparam logic [15:0] COUNT_A_LOW_OFS  = 16'hF800;
  localparam logic [15:0] COUNT_A_HIGH_OFS = 16'hF802;
  localparam logic [15:0] COUNT_B_LOW_OFS  = 16'hF804;
  localparam logic [15:0] COUNT_B_HIGH_OFS = 16'hF806;
  localparam logic [15:0] CONV_MODE_OFS    = 16'hF808;
  localparam logic [15:0] CONV_CTRL_OFS    = 16'hF80A;

  // ***************************************************
  // Field positions and reset values
  // ***************************************************
  localparam int          OSC_MODE_LSB     = 0;
  localparam int          IRQ_SRC_BIT      = 4;
  localparam int          BASE_CLK_LSB     = 5;
  localparam int          SUPPLY_RANGE_BIT = 8;
  localparam int          RUN_BIT          = 0;
  localparam logic [15:0] MODE_RESET       = 16'h0000;
  localparam logic [15:0] CTRL_RESET       = 16'h0000;
  localparam logic [15:0] MODE_USED_MASK   = 16'h01FF;
  localparam logic [15:0] CTRL_USED_MASK   = 16'h0001;

  // ***************************************************
  // Counters
  // ***************************************************
  localparam int          COUNT_W          = 24;
  localparam logic [23:0] COUNT_MAX        = 24'hFFFFFF;
  localparam logic [23:0] COUNT_RESET      = 24'h000000;
  localparam logic [5:0]  DIV_RESET        = 6'h00;

  // Base clock selection codes
  typedef enum logic [2:0] {
    RCADC_BASE_LOW   = 3'b000,
    RCADC_BASE_HIGH  = 3'b001,
    RCADC_BASE_DIV2  = 3'b010,
    RCADC_BASE_DIV4  = 3'b011,
    RCADC_BASE_DIV8  = 3'b100,
    RCADC_BASE_DIV16 = 3'b101,
    RCADC_BASE_DIV32 = 3'b110,
    RCADC_BASE_DIV64 = 3'b111
  } rcadc_base_sel_t;

endpackage

// *** logic/rcadc_base_clk.sv ***
// Base count clock selector and high-speed prescaler of the converter
`timescale 1ns/1ns
`default_nettype none
module rcadc_base_clk (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  // Control
  input  wire logic       i_run,
  input  wire logic [2:0] i_base_clock_sel,
  // Source clock enables
  input  wire logic       i_low_speed_clock,
  input  wire logic       i_high_speed_clock,
  // Selected base count clock enable
  output logic            o_base_count_clock
);

  // ***************************************************
  // Prescaler state
  // ***************************************************
  typedef struct packed {
    logic [5:0] div;
  } rcadc_div_state_t;

  rcadc_div_state_t st_q;
  rcadc_div_state_t st_d;

  // Prescaler restarts while stopped so each run begins with a fixed phase
  always_comb begin
    st_d = st_q;
    if (!i_run) begin
      st_d.div = rcadc_pkg::DIV_RESET;
    end else if (i_high_speed_clock) begin
      st_d.div = st_q.div + 6'h01;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_q.div <= rcadc_pkg::DIV_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Divided tick: last high-speed tick of each 2^n group
  always_comb begin
    case (rcadc_pkg::rcadc_base_sel_t'(i_base_clock_sel))
      rcadc_pkg::RCADC_BASE_LOW:   o_base_count_clock = i_low_speed_clock;   // R03
      rcadc_pkg::RCADC_BASE_HIGH:  o_base_count_clock = i_high_speed_clock;
      rcadc_pkg::RCADC_BASE_DIV2:  o_base_count_clock = i_high_speed_clock & (&st_q.div[0:0]);
      rcadc_pkg::RCADC_BASE_DIV4:  o_base_count_clock = i_high_speed_clock & (&st_q.div[1:0]);
      rcadc_pkg::RCADC_BASE_DIV8:  o_base_count_clock = i_high_speed_clock & (&st_q.div[2:0]);
      rcadc_pkg::RCADC_BASE_DIV16: o_base_count_clock = i_high_speed_clock & (&st_q.div[3:0]);
      rcadc_pkg::RCADC_BASE_DIV32: o_base_count_clock = i_high_speed_clock & (&st_q.div[4:0]);
      rcadc_pkg::RCADC_BASE_DIV64: o_base_count_clock = i_high_speed_clock & (&st_q.div[5:0]);
      default:                     o_base_count_clock = 1'b0;
    endcase
  end

endmodule // rcadc_base_clk
`default_nettype wire

// *** logic/rcadc_ctrl.sv ***
// Control, registers and counters of the RC-oscillation converter
//
// Overview of operation
// R01: The mode register holds a four-bit oscillation mode, codes 0000-0111 valid, top bit set prohibited.
// R02: Mode bit 4 routes the interrupt from counter A overflow when zero, counter B when one.
// R03: Mode bits 7-5 pick counter A's clock: low speed, high speed, or high speed over 2 to 64.
// R04: Mode bit 8 stores the supply range choice and does not touch the counting logic.
// R05: Control bit 0 starts conversion when written one and stops it when written zero.
// R06: While running, an overflow of either counter clears the run bit by itself.
// R07: The run bit is zero after reset so conversion starts stopped.
// R08: Software sets the block disable after stopping and clears it, reprograms and runs to restart.
// R09: Counter A is a 24-bit up-counter of the base clock that overflows after all ones.
// R10: Counter B is a 24-bit up-counter of the oscillator clock that overflows after all ones.
// R11: Each counter has its own overflow flag, and either may raise the interrupt as selected.
// R12: With the run bit at zero the oscillator is held stopped and neither counter moves.
// R13: Setting the run bit starts the oscillator and both counters together.
// R14: Mode and control are 16-bit registers with byte or halfword access, resetting to zero.
// R15: Counter writes preload the count; reads give the preload while running, the count otherwise.
// R16: The interrupt is a one-cycle pulse for the roll-over of the selected counter.
`timescale 1ns/1ns
`default_nettype none
module rcadc_ctrl (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // Special function register port
  input  wire logic [15:0] i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [1:0]  i_sfr_be,
  input  wire logic [15:0] i_sfr_wdata,
  output logic      [15:0] o_sfr_rdata,
  // Count clock enables, one core cycle each
  input  wire logic        i_low_speed_clock,
  input  wire logic        i_high_speed_clock,
  input  wire logic        i_rc_osc_clock,
  // Oscillator control
  output logic             o_osc_run,
  output logic      [3:0]  o_osc_mode_sel,
  output logic             o_supply_range_sel,
  // Status and interrupt
  output logic             o_count_a_overflow,
  output logic             o_count_b_overflow,
  output logic             o_conversion_irq
);

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    logic [15:0] mode;
    logic        run;
    logic [23:0] pre_a;
    logic [23:0] cnt_a;
    logic [23:0] pre_b;
    logic [23:0] cnt_b;
    logic        ovf_a;
    logic        ovf_b;
    logic        irq;
    logic [15:0] rdata;
  } rcadc_state_t;

  rcadc_state_t st_q;
  rcadc_state_t st_d;
  logic         base_tick;

  // Byte-lane merge of a halfword write
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // Halfword address match
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
    hit = (addr[15:1] == ofs[15:1]);
  endfunction

  // ***************************************************
  // Base clock selection
  // ***************************************************
  rcadc_base_clk u_base_clk (
    .i_core_clk         (i_core_clk),
    .i_rst_n            (i_rst_n),
    .i_run              (st_q.run),
    .i_base_clock_sel   (st_q.mode[rcadc_pkg::BASE_CLK_LSB +: 3]), // R03
    .i_low_speed_clock  (i_low_speed_clock),
    .i_high_speed_clock (i_high_speed_clock),
    .o_base_count_clock (base_tick)
  );

  // ***************************************************
  // Next-state logic
  // ***************************************************
  always_comb begin
    logic        wr_a_lo;
    logic        wr_a_hi;
    logic        wr_b_lo;
    logic        wr_b_hi;
    logic        roll_a;
    logic        roll_b;
    logic [15:0] tmp;
    logic [23:0] view_a;
    logic [23:0] view_b;
    st_d    = st_q;
    // Read view, preload shown while running and count when stopped
    view_a  = st_q.run ? st_q.pre_a : st_q.cnt_a;                  // R15
    view_b  = st_q.run ? st_q.pre_b : st_q.cnt_b;
    wr_a_lo = i_sfr_wr & hit(i_sfr_addr, rcadc_pkg::COUNT_A_LOW_OFS);
    wr_a_hi = i_sfr_wr & hit(i_sfr_addr, rcadc_pkg::COUNT_A_HIGH_OFS);
    wr_b_lo = i_sfr_wr & hit(i_sfr_addr, rcadc_pkg::COUNT_B_LOW_OFS);
    wr_b_hi = i_sfr_wr & hit(i_sfr_addr, rcadc_pkg::COUNT_B_HIGH_OFS);
    // Counters only move while running; oscillator held stopped otherwise
    roll_a  = st_q.run & base_tick & (st_q.cnt_a == rcadc_pkg::COUNT_MAX);      // R09 R12
    roll_b  = st_q.run & i_rc_osc_clock & (st_q.cnt_b == rcadc_pkg::COUNT_MAX); // R10 R12
    tmp     = 16'h0000;

    // Counting, both counters released by the same run bit
    if (st_q.run && base_tick) begin
      st_d.cnt_a = st_q.cnt_a + 24'h000001;                        // R09 R13
    end
    if (st_q.run && i_rc_osc_clock) begin
      st_d.cnt_b = st_q.cnt_b + 24'h000001;                        // R10 R13
    end

    // Counter writes preload both the shadow and the live count
    if (wr_a_lo) begin
      tmp         = merge16(st_q.pre_a[15:0], i_sfr_wdata, i_sfr_be);
      st_d.pre_a  = {st_q.pre_a[23:16], tmp};                      // R15
      st_d.cnt_a  = {st_q.pre_a[23:16], tmp};
    end else if (wr_a_hi) begin
      tmp         = merge16({8'h00, st_q.pre_a[23:16]}, i_sfr_wdata, i_sfr_be);
      st_d.pre_a  = {tmp[7:0], st_q.pre_a[15:0]};                  // R15
      st_d.cnt_a  = {tmp[7:0], st_q.pre_a[15:0]};
    end
    if (wr_b_lo) begin
      tmp         = merge16(st_q.pre_b[15:0], i_sfr_wdata, i_sfr_be);
      st_d.pre_b  = {st_q.pre_b[23:16], tmp};                      // R15
      st_d.cnt_b  = {st_q.pre_b[23:16], tmp};
    end else if (wr_b_hi) begin
      tmp         = merge16({8'h00, st_q.pre_b[23:16]}, i_sfr_wdata, i_sfr_be);
      st_d.pre_b  = {tmp[7:0], st_q.pre_b[15:0]};                  // R15
      st_d.cnt_b  = {tmp[7:0], st_q.pre_b[15:0]};
    end

    // Mode register keeps only its defined bits, reserved bits read zero
    if (i_sfr_wr && hit(i_sfr_addr, rcadc_pkg::CONV_MODE_OFS)) begin
      st_d.mode = merge16(st_q.mode, i_sfr_wdata, i_sfr_be) & rcadc_pkg::MODE_USED_MASK; // R01 R14
    end

    // Run bit: software write, then overflow clear takes priority
    if (i_sfr_wr && hit(i_sfr_addr, rcadc_pkg::CONV_CTRL_OFS) && i_sfr_be[0]) begin
      st_d.run = i_sfr_wdata[rcadc_pkg::RUN_BIT];                  // R05 R14
      if (i_sfr_wdata[rcadc_pkg::RUN_BIT] && !st_q.run) begin
        st_d.ovf_a = 1'b0;                                         // Flags restart per conversion
        st_d.ovf_b = 1'b0;
      end
    end
    if (roll_a || roll_b) begin
      st_d.run = 1'b0;                                             // R06
    end

    // Overflow flags: set wins over the clear at a new start
    if (roll_a) begin
      st_d.ovf_a = 1'b1;                                           // R11
    end
    if (roll_b) begin
      st_d.ovf_b = 1'b1;                                           // R11
    end

    // Interrupt pulse for the selected counter only
    st_d.irq = st_q.mode[rcadc_pkg::IRQ_SRC_BIT] ? roll_b : roll_a; // R02 R16

    // Read data from the addressed register, unmapped addresses give zero
    if (i_sfr_rd) begin
      if (hit(i_sfr_addr, rcadc_pkg::COUNT_A_LOW_OFS)) begin
        st_d.rdata = view_a[15:0];
      end else if (hit(i_sfr_addr, rcadc_pkg::COUNT_A_HIGH_OFS)) begin
        st_d.rdata = {8'h00, view_a[23:16]};
      end else if (hit(i_sfr_addr, rcadc_pkg::COUNT_B_LOW_OFS)) begin
        st_d.rdata = view_b[15:0];
      end else if (hit(i_sfr_addr, rcadc_pkg::COUNT_B_HIGH_OFS)) begin
        st_d.rdata = {8'h00, view_b[23:16]};
      end else if (hit(i_sfr_addr, rcadc_pkg::CONV_MODE_OFS)) begin
        st_d.rdata = st_q.mode;
      end else if (hit(i_sfr_addr, rcadc_pkg::CONV_CTRL_OFS)) begin
        st_d.rdata = {15'h0000, st_q.run} & rcadc_pkg::CTRL_USED_MASK;
      end else begin
        st_d.rdata = 16'h0000;                                     // Unmapped reads zero
      end
    end
  end

  // ***************************************************
  // State register
  // ***************************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_q.mode  <= rcadc_pkg::MODE_RESET;                         // R14
      st_q.run   <= rcadc_pkg::CTRL_RESET[0];                      // R07
      st_q.pre_a <= rcadc_pkg::COUNT_RESET;
      st_q.cnt_a <= rcadc_pkg::COUNT_RESET;
      st_q.pre_b <= rcadc_pkg::COUNT_RESET;
      st_q.cnt_b <= rcadc_pkg::COUNT_RESET;
      st_q.ovf_a <= 1'b0;
      st_q.ovf_b <= 1'b0;
      st_q.irq   <= 1'b0;
      st_q.rdata <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************
  // Outputs, all straight from flip-flops
  // ***************************************************
  assign o_sfr_rdata        = st_q.rdata;
  assign o_osc_run          = st_q.run;                            // R12 R13
  assign o_osc_mode_sel     = st_q.mode[rcadc_pkg::OSC_MODE_LSB +: 4]; // R01
  assign o_supply_range_sel = st_q.mode[rcadc_pkg::SUPPLY_RANGE_BIT];  // R04
  assign o_count_a_overflow = st_q.ovf_a;
  assign o_count_b_overflow = st_q.ovf_b;
  assign o_conversion_irq   = st_q.irq;

endmodule // rcadc_ctrl
`default_nettype wire

// *** verification/rcadc_ctrl_sva.sv ***
// Port-level assertion checker of the converter control block
`timescale 1ns/1ns
`default_nettype none
module rcadc_ctrl_sva (
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  // Register port
  input wire logic [15:0] i_sfr_addr,
  input wire logic        i_sfr_wr,
  input wire logic        i_sfr_rd,
  input wire logic [1:0]  i_sfr_be,
  input wire logic [15:0] i_sfr_wdata,
  input wire logic [15:0] o_sfr_rdata,
  // Block outputs
  input wire logic        o_osc_run,
  input wire logic [3:0]  o_osc_mode_sel,
  input wire logic        o_supply_range_sel,
  input wire logic        o_count_a_overflow,
  input wire logic        o_count_b_overflow,
  input wire logic        o_conversion_irq
);
  // ****************
  // Decoded accesses
  // ****************
  wire mode_hit = i_sfr_addr[15:1] == rcadc_pkg::CONV_MODE_OFS[15:1];
  wire ctrl_hit = i_sfr_addr[15:1] == rcadc_pkg::CONV_CTRL_OFS[15:1];
  wire ctrl_wr  = i_sfr_wr && i_sfr_be[0] && ctrl_hit;
  wire mode_wr  = i_sfr_wr && mode_hit;
  logic src_q;
  // Mirror of the source select, so the irq route is judged without peeking inside
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      src_q <= 1'b0;
    end else if (mode_wr && i_sfr_be[0]) begin
      src_q <= i_sfr_wdata[4];
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // ****************
  // Properties
  // ****************
  a_irq_one_cycle: assert property (o_conversion_irq |=> !o_conversion_irq)
    else $error("irq pulse longer than one cycle");
  a_irq_route: assert property ((src_q ? $rose(o_count_b_overflow)
    : $rose(o_count_a_overflow)) == o_conversion_irq)
    else $error("irq does not follow the selected overflow");
  a_ovf_a_stops: assert property ($rose(o_count_a_overflow) |-> $past(o_osc_run) && !o_osc_run)
    else $error("counter A overflow without run clear");
  a_ovf_b_stops: assert property ($rose(o_count_b_overflow) |-> $past(o_osc_run) && !o_osc_run)
    else $error("counter B overflow without run clear");
  a_reset_idle: assert property ($rose(i_rst_n) |-> !o_osc_run && !o_conversion_irq)
    else $error("run or irq set after reset");
  a_run_start: assert property (ctrl_wr && i_sfr_wdata[0] && !o_osc_run |=> o_osc_run)
    else $error("run write of one ignored");
  a_run_stop: assert property (ctrl_wr && !i_sfr_wdata[0] |=> !o_osc_run)
    else $error("run write of zero ignored");
  a_run_stays_off: assert property (!o_osc_run && !ctrl_wr |=> !o_osc_run)
    else $error("run set without a write");
  a_mode_follow: assert property (mode_wr && i_sfr_be[0] |=>
    o_osc_mode_sel == $past(i_sfr_wdata[3:0])) else $error("osc mode not stored");
  a_supply_follow: assert property (mode_wr && i_sfr_be[1] |=>
    o_supply_range_sel == $past(i_sfr_wdata[8])) else $error("supply range not stored");
  a_ctrl_readback: assert property (i_sfr_rd && ctrl_hit |=>
    o_sfr_rdata == {15'h0000, $past(o_osc_run)}) else $error("control read wrong");
  a_flag_holds: assert property (o_count_a_overflow && !ctrl_wr |=> o_count_a_overflow)
    else $error("overflow flag lost");
  // Main scenarios reached
  c_irq: cover property (o_conversion_irq);
  c_ovf_b: cover property ($rose(o_count_b_overflow));
  c_sw_stop: cover property (ctrl_wr && !i_sfr_wdata[0] && o_osc_run);
endmodule // rcadc_ctrl_sva
bind rcadc_ctrl rcadc_ctrl_sva i_rcadc_ctrl_sva (.i_core_clk, .i_rst_n, .i_sfr_addr, .i_sfr_wr,
  .i_sfr_rd, .i_sfr_be, .i_sfr_wdata, .o_sfr_rdata, .o_osc_run, .o_osc_mode_sel,
  .o_supply_range_sel, .o_count_a_overflow, .o_count_b_overflow, .o_conversion_irq);
`default_nettype wire

// *** verification/rcadc_osc_model.sv ***
// Behavioural sensor oscillator that ticks only while the converter runs
`timescale 1ns/1ns
`default_nettype none
module rcadc_osc_model (
  // Clock
  input  wire logic       i_core_clk,
  // Enable and period in core cycles
  input  wire logic       i_run,
  input  wire logic [7:0] i_period,
  // Oscillator tick
  output logic            o_tick
);
  logic [7:0] cnt_q;
  // Held at zero while off, so each run starts a full period late
  always_ff @(posedge i_core_clk) begin
    if (!i_run) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= (cnt_q == i_period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    end
  end
  // No tick outside a conversion
  assign o_tick = i_run && (cnt_q == i_period - 8'h01);
endmodule // rcadc_osc_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench of the converter control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  // ****************
  // Signals
  // ****************
  typedef struct {logic [15:0] mode; logic [23:0] pre; logic low; int n; logic irq;} rcadc_row_t;
  localparam logic [15:0] MODE_A = rcadc_pkg::CONV_MODE_OFS;
  localparam logic [15:0] CTRL_A = rcadc_pkg::CONV_CTRL_OFS;
  localparam logic [15:0] A_LO   = rcadc_pkg::COUNT_A_LOW_OFS;
  localparam logic [15:0] B_LO   = rcadc_pkg::COUNT_B_LOW_OFS;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [15:0] i_sfr_addr = 16'h0000;
  logic        i_sfr_wr = 1'b0;
  logic        i_sfr_rd = 1'b0;
  logic [1:0]  i_sfr_be = 2'h0;
  logic [15:0] i_sfr_wdata = 16'h0000;
  logic        i_low_speed_clock = 1'b0;
  logic        i_high_speed_clock = 1'b1;
  logic [7:0]  osc_period = 8'h28;
  logic        rc_tick;
  logic [15:0] o_sfr_rdata;
  logic [3:0]  o_osc_mode_sel;
  logic        o_osc_run, o_supply_range_sel, o_count_a_overflow, o_count_b_overflow;
  logic        o_conversion_irq;
  logic [15:0] rd_q;
  int          err_count = 0;
  int          n_tests = 0;
  int          n;
  // Preload near the top, so each divider shows as cycles to overflow
  rcadc_row_t  rows [9] = '{
    '{16'h0000, 24'hFFFFFF, 1'b1, 1, 1'b1},
    '{16'h0020, 24'hFFFFFE, 1'b0, 2, 1'b1},
    '{16'h0040, 24'hFFFFFF, 1'b0, 2, 1'b1},
    '{16'h0060, 24'hFFFFFF, 1'b0, 4, 1'b1},
    '{16'h0080, 24'hFFFFFF, 1'b0, 8, 1'b1},
    '{16'h00A0, 24'hFFFFFF, 1'b0, 16, 1'b1},
    '{16'h00C0, 24'hFFFFFF, 1'b0, 32, 1'b1},
    '{16'h00E0, 24'hFFFFFF, 1'b0, 64, 1'b1},
    '{16'h0130, 24'hFFFFFF, 1'b0, 1, 1'b0}};
  // ****************
  // Instances and clock
  // ****************
  always #5 i_core_clk = ~i_core_clk;
  rcadc_ctrl i_rcadc_ctrl (.i_core_clk, .i_rst_n, .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_be,
    .i_sfr_wdata, .o_sfr_rdata, .i_low_speed_clock, .i_high_speed_clock,
    .i_rc_osc_clock(rc_tick), .o_osc_run, .o_osc_mode_sel, .o_supply_range_sel,
    .o_count_a_overflow, .o_count_b_overflow, .o_conversion_irq);
  rcadc_osc_model i_rcadc_osc_model (.i_core_clk, .i_run(o_osc_run), .i_period(osc_period),
    .o_tick(rc_tick));
  // ****************
  // Tasks
  // ****************
  task automatic finish_test();
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // All inputs move 1 ns after the edge, away from sampling
  task automatic step();
    @(posedge i_core_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
    step();
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_be = be;
    i_sfr_wr = 1'b1;
    step();
    i_sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    step();
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    step();
    i_sfr_rd = 1'b0;
    rd_q = o_sfr_rdata;
  endtask
  // Both halves written, the high one carrying count bits 23:16
  task automatic load(input logic [15:0] a, input logic [23:0] v);
    wr(a, v[15:0], 2'b11);
    wr(a + 16'h0002, {8'h00, v[23:16]}, 2'b11);
  endtask
  task automatic wait_stop(input int lim);
    n = 0;
    while (o_osc_run === 1'b1 && n < lim) begin
      step();
      n++;
    end
    if (o_osc_run !== 1'b0) begin
      err_count++;
      finish_test();
    end
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (2) step();
    i_rst_n = 1'b1;
    `CHK("run_rst", 1'b0, o_osc_run)
    rd(MODE_A);
    `CHK("mode_rst", 16'h0000, rd_q)
    rd(CTRL_A);
    `CHK("ctrl_rst", 16'h0000, rd_q)
    wr(MODE_A, 16'hFFFF, 2'b10);
    rd(MODE_A);
    `CHK("mode_hi", 16'h0100, rd_q)
    wr(MODE_A, 16'hFFFF, 2'b01);
    rd(MODE_A);
    `CHK("mode_all", 16'h01FF, rd_q)
    wr(CTRL_A, 16'hFFFF, 2'b10);
    rd(CTRL_A);
    `CHK("ctrl_hi", 16'h0000, rd_q)
    rd(16'hF80C);
    `CHK("unmapped", 16'h0000, rd_q)
    for (int i = 0; i < 16; i++) begin
      wr(MODE_A, 16'(i), 2'b01);
      `CHK("osc_mode", 4'(i), o_osc_mode_sel)
    end
    foreach (rows[r]) begin
      i_low_speed_clock = rows[r].low;
      wr(MODE_A, rows[r].mode, 2'b11);
      load(A_LO, rows[r].pre);
      load(B_LO, 24'h000000);
      wr(CTRL_A, 16'h0001, 2'b01);
      wait_stop(200);
      `CHK("cycles", rows[r].n, n)
      `CHK("irq", rows[r].irq, o_conversion_irq)
      `CHK("ovf_a", 1'b1, o_count_a_overflow)
      `CHK("ovf_b", 1'b0, o_count_b_overflow)
      `CHK("supply", rows[r].mode[8], o_supply_range_sel)
      rd(A_LO);
      `CHK("count_a", 16'h0000, rd_q)
    end
    // Software stop mid-count: the count freezes and reads back live
    i_low_speed_clock = 1'b0;
    wr(MODE_A, 16'h0020, 2'b11);
    load(A_LO, 24'h000000);
    wr(CTRL_A, 16'h0001, 2'b01);
    repeat (9) step();
    wr(CTRL_A, 16'h0000, 2'b01);
    rd(A_LO);
    `CHK("count_stop", 16'h000B, rd_q)
    repeat (10) step();
    rd(A_LO);
    `CHK("count_frozen", 16'h000B, rd_q)
    // Counter B drives the interrupt; counter A on the slowest divider
    osc_period = 8'h05;
    wr(MODE_A, 16'h00F0, 2'b11);
    load(A_LO, 24'h000000);
    load(B_LO, 24'hFFFFFE);
    wr(CTRL_A, 16'h0001, 2'b01);
    rd(B_LO);
    `CHK("preload_b", 16'hFFFE, rd_q)
    rd(B_LO + 16'h0002);
    `CHK("preload_b_hi", 16'h00FF, rd_q)
    wait_stop(100);
    `CHK("irq_b", 1'b1, o_conversion_irq)
    `CHK("ovf_b_set", 1'b1, o_count_b_overflow)
    `CHK("ovf_a_clr", 1'b0, o_count_a_overflow)
    rd(B_LO);
    `CHK("count_b", 16'h0000, rd_q)
    rd(A_LO);
    `CHK("count_a_div", 16'h0000, rd_q)
    finish_test();
  end
endmodule // tb
`default_nettype wire
